// ==== rtl/jfs_sync_hdr_tx.sv ====
// What this block does
// - Mode value 2 selects FEC stream content
// - Parity over all 2048 multiblock bits
// - Parity sent in following multiblock's stream
// - Stream positions: parity, flag, parity, zeros, one
// - End flag set only in final multiblock
// - Generator polynomial degree 26, Fire code
// - Clear stages per multiblock, headers excluded
// - Programmable serializer pre-emphasis level
// - Disabled link: reset, power down, gate clocks
// - Enabling link starts with configured parameters
// - Header 01 sends one, 10 sends zero
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps

`include "jfs_params.svh"

module jfs_sync_hdr_tx (
	// Clock and reset
	input  wire logic             clock_in,
	input  wire logic             rst_n_in,
	// Register port
	input  wire logic [7:0]       reg_addr_in,
	input  wire logic [31:0]      reg_wdata_in,
	input  wire logic             reg_wr_in,
	input  wire logic             reg_rd_in,
	output logic      [31:0]      reg_rdata_out,
	// Scrambled block bits, transmission order
	input  wire logic             blk_bit_in,
	input  wire logic             blk_bit_valid_in,
	// Sync header per block
	output logic      [1:0]       sh_out,
	output logic                  sh_valid_out,
	output logic      [4:0]       sh_pos_out,
	// Link and serializer control
	output logic                  link_rst_n_out,
	output logic                  ser_pd_out,
	output logic                  clk_gate_en_out,
	output logic      [3:0]       serializer_preemph_level_out
);

	import jfs_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic         link_enable_ctl_r;      // Link enable control
	jfs_mode_t    sync_header_mode_sel_r; // Sync header mode
	logic [3:0]   preemph_r;              // Pre-emphasis level
	logic [4:0]   emb_last_r;             // Multiblocks per extended multiblock, minus one
	jfs_link_st_t st_r;                   // Link state
	jfs_link_st_t st_nxt;                 // Next link state
	logic         run;                    // Link running
	logic         fec_on;                 // FEC content selected
	logic         in_fire;                // Input bit taken
	logic [5:0]   bit_r;                  // Bit within block
	logic [4:0]   blk_r;                  // Block within multiblock
	logic [4:0]   mb_r;                   // Multiblock within extended multiblock
	logic         mb_start;               // First bit of a multiblock
	logic         mb_last;                // Last bit of a multiblock
	logic         done_r;                 // Multiblock parity complete
	jfs_parity_t  lfsr_q;                 // Running parity state
	jfs_parity_t  parity_r;               // Parity of previous multiblock
	jfs_parity_t  par_cur;                // Parity to send now
	logic         end_ext_multiblock_flag; // Final multiblock marker
	logic [31:0]  stream;                 // Header stream of this multiblock
	logic [31:0]  rd_mux;                 // Read data selection

	// ----------------------------------------
	// Register writes
	// ----------------------------------------

	// Control register: enable and mode
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			link_enable_ctl_r      <= 1'b0;
			sync_header_mode_sel_r <= 2'h0;
		end
		else if (reg_wr_in && reg_addr_in == `JFS_REG_CTRL)
		begin
			link_enable_ctl_r      <= reg_wdata_in[`JFS_CTRL_EN_BIT];
			sync_header_mode_sel_r <= reg_wdata_in[`JFS_CTRL_MODE_LO +: 2];
		end
	end

	// Pre-emphasis register
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			preemph_r <= `JFS_PE_RST;
		else if (reg_wr_in && reg_addr_in == `JFS_REG_PREEMPH)
			preemph_r <= reg_wdata_in[3:0];
	end

	// Extended multiblock length register
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			emb_last_r <= `JFS_EMB_RST;
		else if (reg_wr_in && reg_addr_in == `JFS_REG_EMB)
			emb_last_r <= reg_wdata_in[4:0];
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------

	// Read selection, unmapped reads as zero
	always_comb
	begin
		case (reg_addr_in)
			`JFS_REG_CTRL:    rd_mux = {29'h0, sync_header_mode_sel_r, link_enable_ctl_r};
			`JFS_REG_PREEMPH: rd_mux = {28'h0, preemph_r};
			`JFS_REG_EMB:     rd_mux = {27'h0, emb_last_r};
			`JFS_REG_STATUS:  rd_mux = {20'h0, mb_r, blk_r, fec_on, run};
			`JFS_REG_PARITY:  rd_mux = {6'h0, parity_r};
			default:          rd_mux = 32'h0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			reg_rdata_out <= 32'h0;
		else if (reg_rd_in)
			reg_rdata_out <= rd_mux;
		else
			reg_rdata_out <= 32'h0;
	end

	// ----------------------------------------
	// Link enable state machine
	// ----------------------------------------

	// Next state follows the enable control
	always_comb
	begin
		case (st_r)
			st_off:  st_nxt = link_enable_ctl_r ? st_run : st_off;
			st_run:  st_nxt = link_enable_ctl_r ? st_run : st_off;
			default: st_nxt = st_off;
		endcase
	end

	// State register
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_r <= st_off;
		else
			st_r <= st_nxt;
	end

	assign run    = (st_r == st_run);
	assign fec_on = (sync_header_mode_sel_r == `JFS_MODE_FEC);

	// Link side controls, held off while disabled
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			link_rst_n_out  <= 1'b0;
			ser_pd_out      <= 1'b1;
			clk_gate_en_out <= 1'b0;
		end
		else
		begin
			link_rst_n_out  <= link_enable_ctl_r;
			ser_pd_out      <= !link_enable_ctl_r;
			clk_gate_en_out <= link_enable_ctl_r;
		end
	end

	// Pre-emphasis level to the serializer
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			serializer_preemph_level_out <= `JFS_PE_RST;
		else
			serializer_preemph_level_out <= preemph_r;
	end

	// ----------------------------------------
	// Block and multiblock position
	// ----------------------------------------

	assign in_fire  = run && blk_bit_valid_in;
	assign mb_start = (bit_r == 6'h00) && (blk_r == 5'h00);
	assign mb_last  = (bit_r == `JFS_BIT_LAST) && (blk_r == `JFS_BLK_LAST);

	// Counters restart from zero whenever the link is disabled
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			bit_r <= 6'h00;
			blk_r <= 5'h00;
			mb_r  <= 5'h00;
		end
		else if (!run)
		begin
			bit_r <= 6'h00;
			blk_r <= 5'h00;
			mb_r  <= 5'h00;
		end
		else if (in_fire)
		begin
			bit_r <= bit_r + 6'h01;
			if (bit_r == `JFS_BIT_LAST)
			begin
				blk_r <= blk_r + 5'h01;
				if (blk_r == `JFS_BLK_LAST)
					mb_r <= (mb_r >= emb_last_r) ? 5'h00 : mb_r + 5'h01;
			end
		end
	end

	assign end_ext_multiblock_flag = (mb_r == emb_last_r);

	// ----------------------------------------
	// Parity generation
	// ----------------------------------------

	// Serial divider, cleared at each multiblock start
	jfs_par_lfsr #(
		.WIDTH (26),
		.POLY  (`JFS_PAR_POLY)
	) u_lfsr (
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.hold_in   (!run),
		.clr_in    (mb_start),
		.en_in     (in_fire),
		.bit_in    (blk_bit_in),
		.state_out (lfsr_q)
	);

	// Completion marker after the 2048th bit
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			done_r <= 1'b0;
		else
			done_r <= in_fire && mb_last;
	end

	// Parity captured for the following multiblock
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			parity_r <= '0;
		else if (!run)
			parity_r <= '0;
		else if (done_r)
			parity_r <= lfsr_q;
	end

	// Bypass so a back-to-back multiblock sees fresh parity
	assign par_cur = done_r ? lfsr_q : parity_r;

	// ----------------------------------------
	// Sync header stream
	// ----------------------------------------

	jfs_stream_map u_map (
		.parity_in  (par_cur),
		.emb_end_in (end_ext_multiblock_flag),
		.fec_on_in  (fec_on),
		.stream_out (stream)
	);

	// One header per block, issued with its first bit
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sh_out       <= 2'h0;
			sh_valid_out <= 1'b0;
			sh_pos_out   <= 5'h00;
		end
		else if (in_fire && bit_r == 6'h00)
		begin
			sh_out       <= stream[blk_r] ? 2'h1 : 2'h2;
			sh_valid_out <= 1'b1;
			sh_pos_out   <= blk_r;
		end
		else
		begin
			sh_valid_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	// Last data bit of a multiblock
	sequence s_mb_last;
		in_fire && mb_last;
	endsequence

	// Parity held one cycle later
	sequence s_capture;
		done_r ##1 (parity_r == $past(lfsr_q));
	endsequence

	chk_fec_mode_sel: assert property (sh_valid_out && !$past(fec_on) && sh_pos_out != `JFS_POS_EMB
		&& sh_pos_out < `JFS_POS_PILOT |-> sh_out == 2'h2)
		else $error("parity field not zero outside fec mode");

	chk_parity_capture: assert property (s_mb_last |=> s_capture)
		else $error("parity not captured after multiblock");

	chk_first_step: assert property (in_fire && mb_start |=>
		lfsr_q == ($past(blk_bit_in) ? `JFS_PAR_POLY : 26'h0))
		else $error("parity not cleared at multiblock start");

	chk_parity_next_mb: assert property (sh_valid_out && sh_pos_out == 5'h01 && fec_on
		|-> sh_out[0] == parity_r[24])
		else $error("previous parity not in stream");

	chk_header_code: assert property (sh_valid_out |-> (sh_out == 2'h1 || sh_out == 2'h2))
		else $error("illegal sync header");

	chk_pilot_tail: assert property (sh_valid_out && sh_pos_out >= `JFS_POS_PILOT
		|-> sh_out == ((sh_pos_out == `JFS_BLK_LAST) ? 2'h1 : 2'h2))
		else $error("pilot pattern wrong");

	chk_emb_flag: assert property (in_fire && bit_r == 6'h00 && blk_r == `JFS_POS_EMB
		|=> sh_out == ($past(mb_r == emb_last_r) ? 2'h1 : 2'h2))
		else $error("end flag wrong");

	chk_link_hold: assert property (!link_enable_ctl_r |=> ser_pd_out && !clk_gate_en_out
		&& !link_rst_n_out ##1 !sh_valid_out)
		else $error("disabled link not held");

	chk_link_release: assert property ($rose(run) |-> bit_r == 6'h00 && blk_r == 5'h00
		&& mb_r == 5'h00 && link_rst_n_out)
		else $error("link did not start clean");

	chk_preemph_out: assert property (reg_wr_in && reg_addr_in == `JFS_REG_PREEMPH |=> ##1
		serializer_preemph_level_out == $past(reg_wdata_in[3:0], 2))
		else $error("pre-emphasis not applied");

endmodule

// ==== rtl/jfs_params.svh ====
`ifndef JFS_PARAMS_SVH
`define JFS_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define JFS_REG_CTRL     8'h00
`define JFS_REG_PREEMPH  8'h04
`define JFS_REG_EMB      8'h08
`define JFS_REG_STATUS   8'h0c
`define JFS_REG_PARITY   8'h10

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define JFS_CTRL_EN_BIT  0
`define JFS_CTRL_MODE_LO 1
`define JFS_CTRL_RST     3'h0
`define JFS_PE_RST       4'h0
`define JFS_EMB_RST      5'h00

// ----------------------------------------
// Coding constants
// ----------------------------------------
`define JFS_MODE_FEC     2'h2
`define JFS_PAR_POLY     26'h0220211
`define JFS_BIT_LAST     6'h3f
`define JFS_BLK_LAST     5'h1f
`define JFS_POS_EMB      5'h16
`define JFS_POS_PILOT    5'h1b

`endif

// ==== rtl/jfs_pkg.sv ====
package jfs_pkg;

	// Link control states
	typedef enum logic
	{
		st_off,
		st_run
	} jfs_link_st_t;

	// Sync header mode selection
	typedef logic [1:0]  jfs_mode_t;

	// Parity word
	typedef logic [25:0] jfs_parity_t;

endpackage

// ==== rtl/jfs_par_lfsr.sv ====
`timescale 1ns/1ps

// Serial parity shift register, one bit per enabled step
module jfs_par_lfsr #(
	parameter int          WIDTH = 26,
	parameter [WIDTH-1:0]  POLY  = {WIDTH{1'b0}}
) (
	// Clock and reset
	input  wire logic             clock_in,
	input  wire logic             rst_n_in,
	// Control
	input  wire logic             hold_in,
	input  wire logic             clr_in,
	input  wire logic             en_in,
	input  wire logic             bit_in,
	// State
	output logic      [WIDTH-1:0] state_out
);

	logic [WIDTH-1:0] base;  // Start value of this step
	logic             fb;    // Feedback bit

	// Cleared start, then one division step
	always_comb
	begin
		base = clr_in ? {WIDTH{1'b0}} : state_out;
		fb   = bit_in ^ base[WIDTH-1];
	end

	// Register update
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state_out <= {WIDTH{1'b0}};
		else if (hold_in)
			state_out <= {WIDTH{1'b0}};
		else if (en_in)
			state_out <= {base[WIDTH-2:0], 1'b0} ^ (fb ? POLY : {WIDTH{1'b0}});
	end

endmodule

// ==== rtl/jfs_stream_map.sv ====
`timescale 1ns/1ps

// Places parity, end flag and pilot into the 32-bit header stream
module jfs_stream_map
	import jfs_pkg::*;
(
	// Content
	input  jfs_pkg::jfs_parity_t parity_in,
	input  wire logic            emb_end_in,
	input  wire logic            fec_on_in,
	// Stream, index is stream position
	output logic [31:0]          stream_out
);

	jfs_parity_t par;  // Parity or zero

	// Position mapping
	always_comb
	begin
		par = fec_on_in ? parity_in : '0;
		for (int i = 0; i < 22; i++)
			stream_out[i] = par[25-i];
		stream_out[22] = emb_end_in;
		for (int i = 0; i < 4; i++)
			stream_out[23+i] = par[3-i];
		stream_out[30:27] = 4'h0;
		stream_out[31]    = 1'b1;
	end

endmodule

// ==== verif/jfs_rx_model.sv ====
`timescale 1ns/1ps

// Far-side receiver: rebuilds each header stream and checks its framing
module jfs_rx_model (
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	// Headers from the transmitter
	input  wire logic [1:0]  sh_in,
	input  wire logic        sh_valid_in,
	input  wire logic [4:0]  sh_pos_in,
	input  wire logic [4:0]  emb_last_in,
	// Data bits as the transmitter takes them
	input  wire logic        data_in,
	input  wire logic        data_valid_in,
	input  wire logic        fec_in,
	// Results
	output logic      [31:0] stream_out,
	output int               err_out,
	output logic             aligned_out
);
	localparam logic [25:0] POLY = 26'h0220211; // Fire code feedback taps

	logic [31:0] acc_r;  // Stream being assembled
	logic [31:0] cur;    // Stream with this header added
	int          mb_r;   // Multiblock index in extended multiblock
	logic [25:0] par_r;  // Own running parity
	logic [25:0] prev_r; // Own parity of the previous multiblock
	logic [25:0] nxt;    // Parity after this bit
	logic [25:0] rxp;    // Parity carried in the stream
	int          nbit_r; // Data bit within multiblock

	// ----------------------------------------
	// Stream assembly and framing checks
	// ----------------------------------------
	always @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			acc_r <= 32'h0;
			mb_r <= 0;
			aligned_out <= 1'b0;
			err_out <= 0;
			stream_out <= 32'h0;
		end
		else if (sh_valid_in)
		begin
			cur = acc_r;
			cur[sh_pos_in] = (sh_in == 2'b01);
			acc_r <= cur;
			// A header that does not toggle is a bad header
			if (sh_in != 2'b01 && sh_in != 2'b10) err_out <= err_out + 1;
			if (sh_pos_in == 5'h1f)
			begin
				stream_out <= cur;
				// Pilot 00001 closes every stream
				if (cur[31:27] != 5'h10) err_out <= err_out + 1;
				// End flag only in last multiblock
				if (cur[22] != (mb_r == emb_last_in)) err_out <= err_out + 1;
				mb_r <= (mb_r == emb_last_in) ? 0 : mb_r + 1;
				// Syndrome against own parity, known 63 blocks after the first bit
				for (int i = 0; i < 22; i++)
					rxp[25 - i] = cur[i];
				for (int i = 0; i < 4; i++)
					rxp[3 - i] = cur[23 + i];
				if ((rxp ^ prev_r) != 26'h0) err_out <= err_out + 1;
				// Extended multiblock end seen: buffering may start at the next one
				if (cur[31:27] == 5'h10 && cur[22]) aligned_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Own parity over the received data bits
	// ----------------------------------------
	always @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			par_r <= 26'h0;
			prev_r <= 26'h0;
			nbit_r <= 0;
		end
		else if (data_valid_in)
		begin
			nxt = {par_r[24:0], 1'b0} ^ ((data_in ^ par_r[25]) ? POLY : 26'h0);
			par_r <= (nbit_r == 2047) ? 26'h0 : nxt;
			nbit_r <= (nbit_r == 2047) ? 0 : nbit_r + 1;
			if (nbit_r == 2047) prev_r <= fec_in ? nxt : 26'h0;
		end
	end
endmodule

// ==== verif/test_jfs_sync_hdr_tx.sv ====
`timescale 1ns/1ps

module test_jfs_sync_hdr_tx;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clock_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	logic        blk_bit_in = 1'b0;
	logic        blk_bit_valid_in = 1'b0;
	logic [1:0]  sh_out;
	logic        sh_valid_out;
	logic [4:0]  sh_pos_out;
	logic        link_rst_n_out;
	logic        ser_pd_out;
	logic        clk_gate_en_out;
	logic [3:0]  serializer_preemph_level_out;
	logic [31:0] rx_stream;
	int          rx_err;
	logic        rx_aligned;
	int          n_mismatch = 0;
	int          checks = 0;
	int          seed = 32'h560ee829;
	// Reference model state
	localparam logic [25:0] POLY = (1 << 21) | (1 << 17) | (1 << 9) | (1 << 4) | 1;
	logic [25:0] par;
	logic [25:0] prev;
	logic [4:0]  emb = 5'h0;
	logic [6:0]  expq[$];
	logic [6:0]  e;
	logic [3:0]  pe;
	int          bitc;
	int          mbi;
	bit          fec;
	bit          run = 0;

	jfs_sync_hdr_tx u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .blk_bit_in(blk_bit_in),
		.blk_bit_valid_in(blk_bit_valid_in), .sh_out(sh_out), .sh_valid_out(sh_valid_out),
		.sh_pos_out(sh_pos_out), .link_rst_n_out(link_rst_n_out), .ser_pd_out(ser_pd_out),
		.clk_gate_en_out(clk_gate_en_out),
		.serializer_preemph_level_out(serializer_preemph_level_out));

	jfs_rx_model u_rx (.clock_in(clock_in), .rst_n_in(link_rst_n_out), .sh_in(sh_out),
		.sh_valid_in(sh_valid_out), .sh_pos_in(sh_pos_out), .emb_last_in(emb),
		.data_in(blk_bit_in), .data_valid_in(blk_bit_valid_in), .fec_in(fec),
		.stream_out(rx_stream), .err_out(rx_err), .aligned_out(rx_aligned));

	always #5 clock_in = ~clock_in;

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		#1;
		cmp(reg_rdata_out, exp);
	endtask

	// Expected header stream of one multiblock
	function automatic logic [31:0] stream_of(input logic [25:0] p, input logic f);
		logic [31:0] s;
		s = 32'h8000_0000;
		for (int i = 0; i < 22; i++)
			s[i] = p[25 - i];
		s[22] = f;
		for (int i = 0; i < 4; i++)
			s[23 + i] = p[3 - i];
		return s;
	endfunction

	// Reference model: one bit taken by a running link
	task automatic take(input logic b);
		logic [31:0] s;
		if (!run) return;
		if (bitc % 64 == 0)
		begin
			s = stream_of(prev, mbi == int'(emb));
			expq.push_back({5'(bitc / 64), s[bitc / 64] ? 2'b01 : 2'b10});
		end
		par = {par[24:0], 1'b0} ^ ((b ^ par[25]) ? POLY : 26'h0);
		bitc++;
		if (bitc == 2048)
		begin
			prev = fec ? par : 26'h0;
			par = 26'h0;
			bitc = 0;
			mbi = (mbi == int'(emb)) ? 0 : mbi + 1;
		end
	endtask

	task automatic send(input int n, input bit gap);
		int k;
		int tries;
		logic b;
		k = 0;
		tries = 0;
		while (k < n && tries < 2 * n + 64)
		begin
			@(posedge clock_in);
			tries++;
			b = $random(seed);
			blk_bit_in <= b;
			if (gap && (($random(seed) & 3) == 0))
				blk_bit_valid_in <= 1'b0;
			else
			begin
				blk_bit_valid_in <= 1'b1;
				take(b);
				k++;
			end
		end
		if (k < n)
		begin
			n_mismatch++;
			$display("[FAIL] %0t send ran out of cycles", $time);
		end
		@(posedge clock_in);
		blk_bit_valid_in <= 1'b0;
		repeat (3) @(posedge clock_in);
	endtask

	// Every header is compared with the model
	always @(posedge clock_in)
	begin
		if (rst_n_in && sh_valid_out !== 1'b0)
		begin
			e = (expq.size() > 0) ? expq.pop_front() : 7'h7f;
			cmp({25'h0, sh_pos_out, sh_out}, {25'h0, e});
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge clock_in);
		rst_n_in <= 1'b1;
		#1;
		cmp({link_rst_n_out, ser_pd_out, clk_gate_en_out, serializer_preemph_level_out}, 32'h20);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h14, 32'h0);
		for (int m = 0; m < 4; m++)
		begin
			// Link off while parameters change
			wr(8'h00, {29'h0, m[1:0], 1'b0});
			repeat (2) @(posedge clock_in);
			cmp({link_rst_n_out, ser_pd_out, clk_gate_en_out}, 32'h2);
			run = 0;
			send(70, 0);
			pe = $random(seed);
			emb = 5'(m);
			wr(8'h04, {28'hfffffff, pe});
			wr(8'h08, {27'h0, emb});
			rd(8'h04, {28'h0, pe});
			rd(8'h08, {27'h0, emb});
			par = 26'h0;
			prev = 26'h0;
			bitc = 0;
			mbi = 0;
			fec = (m == 2);
			wr(8'h00, {29'h0, m[1:0], 1'b1});
			run = 1;
			repeat (2) @(posedge clock_in);
			cmp({link_rst_n_out, ser_pd_out, clk_gate_en_out, serializer_preemph_level_out},
				{25'h0, 3'h5, pe});
			send(2048 * 3, m[0]);
			if (fec)
				rd(8'h10, {6'h0, prev});
			// Abort a multiblock part way through
			send(100, 0);
			rd(8'h0c, {20'h0, 5'(mbi), 5'(bitc / 64), fec, 1'b1});
			cmp(32'(rx_err), 32'h0);
			cmp({31'h0, rx_aligned}, {31'h0, m < 3});
			cmp({26'h0, rx_stream[31:27], rx_stream[22]},
				{26'h0, 5'h10, (2 % (m + 1)) == m});
		end
		cmp(32'(expq.size()), 32'h0);
		cmp(32'(rx_err), 32'h0);
		wrap_up();
	end
endmodule
